// *** src/quad_card_pkg.sv ***
// constants, types and state layout for the quadrature counter card
package quad_card_pkg;
	localparam int MAX_AXES = 4;
	localparam int CNT_W = 24;
	localparam int MCLK_HZ = 100_000_000;
	localparam int COUNT_RATE_HZ = 12_000_000;
	localparam int EDGE_CYC = MCLK_HZ / COUNT_RATE_HZ;
	localparam int FILT_LEN = EDGE_CYC / 2;
	localparam logic [6:0] SHIPPED_SWITCH = 7'h30;
	localparam logic [3:0] OFS_AXIS_STRIDE = 4'h2;
	localparam logic [3:0] OFS_IRQ_FLAGS = 4'h8;
	localparam logic [3:0] OFS_IRQ_CLEAR = 4'hc;
	localparam logic [1:0] SUB_CMD = 2'h0;
	localparam logic [1:0] SUB_CB_CFG = 2'h1;
	localparam logic [1:0] SUB_IDX_CFG = 2'h2;
	localparam logic [1:0] SUB_EXT_CFG = 2'h3;
	localparam logic [1:0] LAST_BYTE = 2'h2;
	localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
	localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

	typedef enum logic [1:0] {ACT_NONE = 2'h0, ACT_CLEAR = 2'h1, ACT_LOAD = 2'h2} act_e;
	typedef enum logic [2:0] {BUS_IDLE = 3'b001, BUS_READ = 3'b010, BUS_WRITE = 3'b100} bus_e;

	typedef struct packed {
		logic iorn;
		logic iown;
		logic aen;
		logic [15:0] sa;
		logic [7:0] sd_in;
	} isa_in_s;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] preset;
		logic [CNT_W-1:0] latch;
		logic [1:0] ptr;
		logic [3:0] cb_cfg;
		logic [2:0] idx_cfg;
		logic [3:0] ext_cfg;
		logic [FILT_LEN-1:0] ha;
		logic [FILT_LEN-1:0] hb;
		logic qa;
		logic qb;
		logic idx_prev;
		logic [1:0] ext_prev;
		logic pending;
		logic pulse;
		logic dir;
	} axis_s;

	typedef struct packed {
		axis_s [MAX_AXES-1:0] ax;
		bus_e bus;
		logic [7:0] sd_out;
		logic sd_oe;
		logic irq;
		logic irq_oe;
	} state_s;
endpackage

// *** src/quad_card.sv ***
// isa address decode, host access and per-axis 24-bit quadrature counters
`timescale 1ns/1ps
`default_nettype none
module quad_card
	import quad_card_pkg::*;
#(
	parameter int NUM_AXES = 4
)(
	input wire logic mclk,
	input wire logic resetn,
	input wire quad_card_pkg::isa_in_s isa,
	input wire logic [6:0] base_address_switch,
	input wire logic irq_jumper_fitted,
	input wire logic [quad_card_pkg::MAX_AXES-1:0] quad_a,
	input wire logic [quad_card_pkg::MAX_AXES-1:0] quad_b,
	input wire logic [quad_card_pkg::MAX_AXES-1:0] index_in,
	input wire logic [quad_card_pkg::MAX_AXES-1:0][1:0] ext_in,
	output logic [7:0] sd_out,
	output logic sd_oe,
	output logic irq,
	output logic irq_oe,
	output logic [quad_card_pkg::MAX_AXES-1:0] flag_pulse
);
	import quad_card_pkg::*;

	state_s s_q;
	state_s s_d;
	logic sel;
	logic start_rd;
	logic start_wr;
	logic [3:0] ofs;
	logic [MAX_AXES-1:0] irq_set;
	logic [MAX_AXES-1:0] pend_vec;

	// open switch reads as one, so the switch word is the address directly
	assign sel = (isa.sa[10:4] == base_address_switch) && (isa.sa[15:11] == 5'h00)
		&& !isa.aen && (!isa.iorn || !isa.iown);
	assign ofs = isa.sa[3:0];
	assign start_rd = sel && (s_q.bus == BUS_IDLE) && !isa.iorn;
	assign start_wr = sel && (s_q.bus == BUS_IDLE) && !isa.iown && isa.iorn;

	always_comb
	begin
		s_d = s_q;
		irq_set = '0;
		for (int i = 0; i < MAX_AXES; i++)
		begin
			pend_vec[i] = s_q.ax[i].pending;
		end
		case (s_q.bus)
			BUS_IDLE:
			begin
				if (start_rd)
					s_d.bus = BUS_READ;
				else if (start_wr)
					s_d.bus = BUS_WRITE;
			end
			BUS_READ:
			begin
				if (isa.iorn)
					s_d.bus = BUS_IDLE;
			end
			BUS_WRITE:
			begin
				if (isa.iown)
					s_d.bus = BUS_IDLE;
			end
			default:
				s_d.bus = BUS_IDLE;
		endcase
		s_d.sd_oe = (s_q.bus == BUS_READ || start_rd) && sel && !isa.iorn;
		if (start_rd && ofs == OFS_IRQ_FLAGS)
			s_d.sd_out = {4'h0, pend_vec};
		else if (start_rd)
			s_d.sd_out = 8'h00;
		if ((start_rd || start_wr) && ofs == OFS_IRQ_CLEAR)
		begin
			for (int i = 0; i < MAX_AXES; i++)
				s_d.ax[i].pending = 1'b0;
		end
		for (int i = 0; i < MAX_AXES; i++)
		begin
			if (i < NUM_AXES)
			begin
				logic hit_data;
				logic hit_ctl;
				logic up;
				logic step;
				logic cy;
				logic bw;
				logic idx_rise;
				logic [1:0] ext_rise;
				act_e act;
				hit_data = (ofs == 4'(i) * OFS_AXIS_STRIDE);
				hit_ctl = (ofs == 4'(i) * OFS_AXIS_STRIDE + 4'h1);
				// history must agree on every sample; glitches shorter than that are dropped
				s_d.ax[i].ha = {s_q.ax[i].ha[FILT_LEN-2:0], quad_a[i]};
				s_d.ax[i].hb = {s_q.ax[i].hb[FILT_LEN-2:0], quad_b[i]};
				if (&s_q.ax[i].ha || ~|s_q.ax[i].ha)
					s_d.ax[i].qa = s_q.ax[i].ha[0];
				if (&s_q.ax[i].hb || ~|s_q.ax[i].hb)
					s_d.ax[i].qb = s_q.ax[i].hb[0];
				// one count per filtered edge; a double change is an illegal jump and is dropped
				step = (s_d.ax[i].qa ^ s_q.ax[i].qa) ^ (s_d.ax[i].qb ^ s_q.ax[i].qb);
				up = (s_q.ax[i].qa == s_d.ax[i].qb);
				cy = step && up && (s_q.ax[i].cnt == CNT_MAX);
				bw = step && !up && (s_q.ax[i].cnt == CNT_ZERO);
				if (step)
				begin
					s_d.ax[i].dir = up;
					s_d.ax[i].cnt = up ? s_q.ax[i].cnt + 24'h000001 : s_q.ax[i].cnt - 24'h000001;
				end
				s_d.ax[i].pulse = (cy || bw) && s_q.ax[i].cb_cfg[3];
				act = ACT_NONE;
				if (cy || bw)
					act = act_e'(s_q.ax[i].cb_cfg[1:0]);
				idx_rise = index_in[i] && !s_q.ax[i].idx_prev;
				s_d.ax[i].idx_prev = index_in[i];
				if (idx_rise && s_q.ax[i].idx_cfg[1:0] != ACT_NONE)
					act = act_e'(s_q.ax[i].idx_cfg[1:0]);
				ext_rise = ext_in[i] & ~s_q.ax[i].ext_prev;
				s_d.ax[i].ext_prev = ext_in[i];
				for (int k = 0; k < 2; k++)
				begin
					if (ext_rise[k] && s_q.ax[i].ext_cfg[k+2])
						act = s_q.ax[i].ext_cfg[k] ? ACT_LOAD : ACT_CLEAR;
				end
				irq_set[i] = ((cy || bw) && s_q.ax[i].cb_cfg[2])
					|| (idx_rise && s_q.ax[i].idx_cfg[2]);
				if (irq_set[i])
					s_d.ax[i].pending = 1'b1; // set wins over clear
				if (start_rd && hit_data)
				begin
					s_d.sd_out = s_q.ax[i].latch[8*s_q.ax[i].ptr +: 8];
					s_d.ax[i].ptr = (s_q.ax[i].ptr == LAST_BYTE) ? 2'h0 : s_q.ax[i].ptr + 2'h1;
				end
				if (start_rd && hit_ctl)
					s_d.sd_out = {4'h0, s_q.ax[i].pending, s_q.ax[i].dir, s_q.ax[i].ptr};
				if (start_wr && hit_data)
				begin
					s_d.ax[i].preset[8*s_q.ax[i].ptr +: 8] = isa.sd_in;
					s_d.ax[i].ptr = (s_q.ax[i].ptr == LAST_BYTE) ? 2'h0 : s_q.ax[i].ptr + 2'h1;
				end
				if (start_wr && hit_ctl)
				begin
					case (isa.sd_in[7:6])
						SUB_CMD:
						begin
							if (isa.sd_in[0])
								act = ACT_CLEAR;
							if (isa.sd_in[1])
								act = ACT_LOAD;
							if (isa.sd_in[2])
								s_d.ax[i].latch = s_q.ax[i].cnt;
							if (isa.sd_in[3])
								s_d.ax[i].ptr = 2'h0;
						end
						SUB_CB_CFG:
							s_d.ax[i].cb_cfg = isa.sd_in[3:0];
						SUB_IDX_CFG:
							s_d.ax[i].idx_cfg = isa.sd_in[2:0];
						SUB_EXT_CFG:
							s_d.ax[i].ext_cfg = isa.sd_in[3:0];
						default:
							s_d.ax[i].cb_cfg = s_q.ax[i].cb_cfg;
					endcase
				end
				case (act)
					ACT_CLEAR:
						s_d.ax[i].cnt = CNT_ZERO;
					ACT_LOAD:
						s_d.ax[i].cnt = s_q.ax[i].preset;
					default:
						s_d.ax[i].cnt = s_d.ax[i].cnt;
				endcase
			end
		end
		for (int i = 0; i < MAX_AXES; i++)
		begin
			pend_vec[i] = s_d.ax[i].pending;
		end
		// line is released unless a level jumper is fitted; shipped with none
		s_d.irq = (|pend_vec) && irq_jumper_fitted;
		s_d.irq_oe = irq_jumper_fitted;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			s_q <= '0;
			s_q.bus <= BUS_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign sd_out = s_q.sd_out;
	assign sd_oe = s_q.sd_oe;
	assign irq = s_q.irq;
	assign irq_oe = s_q.irq_oe;
	always_comb
	begin
		for (int i = 0; i < MAX_AXES; i++)
			flag_pulse[i] = s_q.ax[i].pulse;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_select;
		(s_q.bus == BUS_IDLE) && !isa.iorn && !isa.aen && isa.sa[15:11] == 5'h00
			&& isa.sa[10:4] == base_address_switch |=> s_q.bus == BUS_READ;
	endproperty
	a_select: assert property (p_select) else $error("matching read not taken");

	property p_no_claim;
		(isa.sa[10:4] != base_address_switch) && s_q.bus == BUS_IDLE |=> !sd_oe;
	endproperty
	a_no_claim: assert property (p_no_claim) else $error("foreign address claimed");

	property p_dma;
		isa.aen && s_q.bus == BUS_IDLE |=> s_q.bus == BUS_IDLE && !sd_oe;
	endproperty
	a_dma: assert property (p_dma) else $error("dma cycle selected card");

	property p_flags_read;
		start_rd && ofs == OFS_IRQ_FLAGS |=> sd_out[7:4] == 4'h0 && sd_oe;
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flag byte wrong");

	// the request line follows the flags with one register, so both are low one cycle on
	property p_clear;
		(start_rd || start_wr) && ofs == OFS_IRQ_CLEAR && irq_set == '0
			|=> !irq && !s_q.ax[0].pending && !s_q.ax[1].pending
			&& !s_q.ax[2].pending && !s_q.ax[3].pending;
	endproperty
	a_clear: assert property (p_clear) else $error("pending not cleared");

	property p_irq_line;
		!irq_jumper_fitted |=> !irq_oe && !irq;
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("irq driven without jumper");

	property p_irq_set;
		irq_set[0] && irq_jumper_fitted |=> irq;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("irq not raised");

	property p_filter;
		$changed(s_q.ax[0].qa) |-> $past(quad_a[0], 2) == s_q.ax[0].qa;
	endproperty
	a_filter: assert property (p_filter) else $error("filter passed unstable input");

	property p_wrap;
		// with no other action armed, leaving the top value upward can only be a carry
		s_q.ax[0].cnt == CNT_MAX && s_q.ax[0].cb_cfg[3] && s_d.ax[0].dir
			&& s_d.ax[0].cnt != CNT_MAX && s_q.ax[0].idx_cfg[1:0] == 2'h0
			&& s_q.ax[0].ext_cfg[3:2] == 2'h0 && !start_wr |=> flag_pulse[0];
	endproperty
	a_wrap: assert property (p_wrap) else $error("carry pulse missing");

	c_read_flags: cover property (start_rd && ofs == OFS_IRQ_FLAGS ##1 sd_out[0]);
	c_clear: cover property (start_wr && ofs == OFS_IRQ_CLEAR ##1 pend_vec == '0);
	c_carry: cover property (flag_pulse[0]);
	c_index_irq: cover property (irq_set[0] && !s_q.ax[0].pending);
endmodule
`default_nettype wire

// *** sim/isa_host.sv ***
// host side model: isa i/o cycles and the shared-interrupt service routine
`timescale 1ns/1ps
`default_nettype none
module isa_host
	import quad_card_pkg::*;
(
	input wire logic mclk,
	output var quad_card_pkg::isa_in_s isa,
	input wire logic [7:0] sd_out,
	input wire logic sd_oe
);
	initial isa = '{iorn: 1'h1, iown: 1'h1, aen: 1'h0, sa: 16'h0000, sd_in: 8'h00};

	// one strobe per access, then idle long enough for the card to rearm
	task automatic cyc(input logic [15:0] a, input logic wr, input logic [7:0] d,
		input logic dma, output logic [7:0] v, output logic oe);
		@(negedge mclk);
		isa = '{iorn: wr, iown: !wr, aen: dma, sa: a, sd_in: d};
		repeat (2) @(negedge mclk);
		v = sd_out;
		oe = sd_oe;
		// released lines carry junk, never the previous value
		isa = '{iorn: 1'h1, iown: 1'h1, aen: 1'h0, sa: ~a, sd_in: ~d};
		repeat (2) @(negedge mclk);
	endtask

	task automatic isr(input logic [15:0] base, output logic [3:0] who);
		logic [7:0] v;
		logic oe;
		cyc(base + 16'h0008, 1'h0, 8'h00, 1'h0, v, oe);
		who = v[3:0];
		cyc(base + 16'h000c, 1'h1, 8'h00, 1'h0, v, oe);
	endtask
endmodule
`default_nettype wire

// *** sim/quad_encoder_card_host_decode_bench.sv ***
// self-checking bench for the quadrature counter card
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_card_host_decode_bench;
	import quad_card_pkg::*;
	localparam logic [15:0] BASE = 16'h0300;
	logic mclk = 1'h0;
	logic resetn = 1'h0;
	isa_in_s isa;
	logic [6:0] sw = SHIPPED_SWITCH;
	logic jmp = 1'h0;
	logic [MAX_AXES-1:0] qa = '0, qb = '0, idx = '0, flag_pulse;
	logic [MAX_AXES-1:0][1:0] ext = '0;
	logic [7:0] sd_out;
	logic sd_oe, irq, irq_oe;
	logic pulse_seen = 1'h0;
	int n_mismatch = 0, check_count = 0, cycles = 0;

	always #5 mclk = ~mclk;

	quad_card uut (.mclk(mclk), .resetn(resetn), .isa(isa), .base_address_switch(sw),
		.irq_jumper_fitted(jmp), .quad_a(qa), .quad_b(qb), .index_in(idx), .ext_in(ext),
		.sd_out(sd_out), .sd_oe(sd_oe), .irq(irq), .irq_oe(irq_oe), .flag_pulse(flag_pulse));
	isa_host host (.mclk(mclk), .isa(isa), .sd_out(sd_out), .sd_oe(sd_oe));

	// the pulse lasts one cycle, so keep a sticky copy taken where it is settled
	always @(negedge mclk)
	begin
		if (flag_pulse[0] === 1'h1)
			pulse_seen <= 1'h1;
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic ctl(input logic [7:0] d);
		logic [7:0] v;
		logic oe;
		host.cyc(BASE + 16'h0001, 1'h1, d, 1'h0, v, oe);
	endtask

	task automatic set_preset(input logic [23:0] p);
		logic [7:0] v;
		logic oe;
		ctl(8'h08);
		for (int i = 0; i < 3; i++)
			host.cyc(BASE, 1'h1, p[8*i +: 8], 1'h0, v, oe);
	endtask

	task automatic get_cnt(output logic [23:0] c);
		logic [7:0] v;
		logic oe;
		ctl(8'h0c);
		for (int i = 0; i < 3; i++)
		begin
			host.cyc(BASE, 1'h0, 8'h00, 1'h0, v, oe);
			c[8*i +: 8] = v;
		end
	endtask

	// n gray steps per call, each held two filter lengths
	task automatic turn(input int n, input logic up);
		for (int i = 0; i < n; i++)
		begin
			{qa[0], qb[0]} = up ? {~qb[0], qa[0]} : {qb[0], ~qa[0]};
			repeat (8) @(negedge mclk);
		end
	endtask

	task automatic s_decode();
		logic [7:0] v;
		logic oe;
		logic [6:0] sws [8] = '{7'h30, 7'h30, 7'h30, 7'h30, 7'h30, 7'h7f, 7'h00, 7'h31};
		logic [15:0] adr [8] = '{16'h0308, 16'h030f, 16'h02ff, 16'h0310, 16'h0b08,
			16'h07f8, 16'h0008, 16'h0318};
		logic [7:0] hit = 8'he3;
		for (int i = 0; i < 8; i++)
		begin
			sw = sws[i];
			host.cyc(adr[i], 1'h0, 8'h00, 1'h0, v, oe);
			chk("select", {hit[i], 8'h00}, {oe, hit[i] ? v : 8'h00});
		end
		sw = SHIPPED_SWITCH;
		host.cyc(16'h0308, 1'h0, 8'h00, 1'h1, v, oe);
		chk("dma cycle", 1'h0, oe);
	endtask

	task automatic s_count();
		logic [23:0] c;
		set_preset(24'h123456);
		ctl(8'h02);
		get_cnt(c);
		chk("preset", 24'h123456, c);
		turn(5, 1'h1);
		turn(2, 1'h0);
		get_cnt(c);
		chk("count", 24'h123459, c);
		qa[0] = ~qa[0];
		repeat (2) @(negedge mclk);
		qa[0] = ~qa[0];
		repeat (8) @(negedge mclk);
		get_cnt(c);
		chk("glitch", 24'h123459, c);
	endtask

	task automatic s_carry();
		logic [23:0] c;
		logic [3:0] who;
		jmp = 1'h1;
		set_preset(24'hffffff);
		ctl(8'h02);
		set_preset(24'h000777);
		ctl(8'h4e);
		pulse_seen = 1'h0;
		turn(1, 1'h1);
		chk("irq pulse", 3'h7, {irq, irq_oe, pulse_seen});
		get_cnt(c);
		chk("carry load", 24'h000777, c);
		host.isr(BASE, who);
		chk("who", 4'h1, who);
		chk("irq clear", 1'h0, irq);
	endtask

	task automatic s_index_ext();
		logic [23:0] c;
		logic [3:0] who;
		ctl(8'h81);
		idx[0] = 1'h1;
		repeat (4) @(negedge mclk);
		idx[0] = 1'h0;
		get_cnt(c);
		chk("index clear", 24'h000000, c);
		ctl(8'hc5);
		ext[0][0] = 1'h1;
		repeat (4) @(negedge mclk);
		ext[0][0] = 1'h0;
		get_cnt(c);
		chk("ext load", 24'h000777, c);
		ctl(8'hcd);
		ext[0][1] = 1'h1;
		repeat (4) @(negedge mclk);
		ext[0][1] = 1'h0;
		get_cnt(c);
		chk("ext clear", 24'h000000, c);
		// index armed to load the preset and to request an interrupt
		ctl(8'h86);
		idx[0] = 1'h1;
		repeat (4) @(negedge mclk);
		idx[0] = 1'h0;
		get_cnt(c);
		chk("index load", 24'h000777, c);
		chk("index irq", 1'h1, irq);
		host.isr(BASE, who);
		chk("index who", 4'h1, who);
		chk("index irq clear", 1'h0, irq);
	endtask

	initial
	begin
		repeat (16) @(negedge mclk);
		resetn = 1'h1;
		@(negedge mclk);
		chk("reset outputs", 7'h00, {sd_oe, irq, irq_oe, flag_pulse});
		s_decode();
		s_count();
		s_carry();
		s_index_ext();
		end_sim();
	end
endmodule
`default_nettype wire
